// ---- shared/sfm_pkg.sv ----
// constants, types and decode functions for the supply fault monitor
package sfm_pkg;

  localparam int NUM_CH = 7;
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_US = 1000;
  localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
  localparam int GF_MAX_US = 100;
  localparam int CNT_W = 15;

  // channel order
  localparam int CH_BIP0 = 0;
  localparam int CH_BIP1 = 1;
  localparam int CH_HV = 2;
  localparam int CH_POS_FIRST = 3;

  // register map
  localparam logic [7:0] CH_BASE = 8'hA0;
  localparam logic [7:0] CH_LAST = 8'hD7;
  localparam logic [2:0] OFF_OV_TH = 3'h0;
  localparam logic [2:0] OFF_OV_HY = 3'h1;
  localparam logic [2:0] OFF_UV_TH = 3'h2;
  localparam logic [2:0] OFF_UV_HY = 3'h3;
  localparam logic [2:0] OFF_SEL = 3'h4;
  localparam logic [7:0] ADDR_STATUS = 8'hE0;
  localparam logic [7:0] ADDR_MASK = 8'hE1;
  localparam logic [7:0] ADDR_LIVE = 8'hE2;

  // values after reset
  localparam logic [7:0] OV_TH_RST = 8'hFF;
  localparam logic [7:0] UV_TH_RST = 8'h00;
  localparam logic [4:0] HY_RST = 5'h00;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [6:0] MASK_RST = 7'h00;

  // select field positions
  localparam int SEL_TYPE_LSB = 0;
  localparam int SEL_RANGE_LSB = 2;
  localparam int SEL_GF_LSB = 4;
  localparam int SEL_POL_BIT = 7;
  localparam int HY_W = 5;

  typedef enum logic [1:0] {
    FT_UV = 2'h0,
    FT_OV = 2'h1,
    FT_WIN = 2'h2
  } sfm_ftype_t;

  typedef enum logic [2:0] {
    RG_MID = 3'h0,
    RG_LOW = 3'h1,
    RG_ULOW = 3'h2,
    RG_HIGH = 3'h3,
    RG_NEG = 3'h4
  } sfm_range_t;

  // glitch filter timeout in microseconds per code
  function automatic int gf_us(input logic [2:0] code);
    case (code)
      3'h0: gf_us = 0;
      3'h1: gf_us = 1;
      3'h2: gf_us = 2;
      3'h3: gf_us = 5;
      3'h4: gf_us = 10;
      3'h5: gf_us = 20;
      3'h6: gf_us = 50;
      default: gf_us = GF_MAX_US;
    endcase
  endfunction

  // range actually applied, illegal codes fall back to the mid range
  function automatic sfm_range_t eff_range(input int ch, input logic [7:0] sel);
    logic [1:0] rs;
    rs = sel[SEL_RANGE_LSB +: 2];
    if (ch <= CH_BIP1 && sel[SEL_POL_BIT])
      eff_range = RG_NEG;
    else
      case (rs)
        2'h1: eff_range = (ch != CH_HV) ? RG_LOW : RG_MID;
        2'h2: eff_range = (ch >= CH_POS_FIRST) ? RG_ULOW : RG_MID;
        2'h3: eff_range = (ch == CH_HV) ? RG_HIGH : RG_MID;
        default: eff_range = RG_MID;
      endcase
  endfunction

endpackage

// ---- logic/sfm_fault_detector.sv ----
// seven channel supply fault monitor: thresholds, hysteresis, fault type, glitch filter
// Summary of operation
// RULE_01: seven channels: two bipolar, one high-voltage, four positive-only.
// RULE_02: each channel applies exactly one fault type at a time.
// RULE_03: undervoltage trips below low threshold, overvoltage trips above high threshold.
// RULE_04: every channel holds its own 8-bit low and high threshold codes.
// RULE_05: trip level is range bottom plus span times code over 255.
// RULE_06: ranges selectable per channel type, bottom one third of top.
// RULE_07: separate low and high hysteresis, only five low bits kept.
// RULE_08: faults release only past threshold plus or minus hysteresis.
// RULE_09: hysteresis is span times 5-bit code over 255, max 31.
// RULE_10: bipolar select bit 7 chooses positive or negative input.
// RULE_11: negative polarity forces the single negative range.
// RULE_12: select bits 1:0 choose type; window is OR of both.
// RULE_13: each channel ends in a glitch filter, timeout up to 100 us.
// RULE_14: pulses shorter than timeout vanish; longer ones pass delayed by it.
// RULE_15: two fault conditions on one rail need two channel inputs.
// RULE_16: host writes thresholds, hysteresis, timeout and type; device applies them.
// RULE_17: high thresholds reset to all ones, everything else to zero.
// RULE_18: polarity bit zero is positive, one is negative.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps
module sfm_fault_detector #(
  parameter int NUM_CH = sfm_pkg::NUM_CH,
  parameter int CYC_PER_US = sfm_pkg::CYC_PER_US
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  input wire logic [NUM_CH*8-1:0] sense_code_in,
  output logic [NUM_CH-1:0] fault_out,
  output logic [NUM_CH*3-1:0] range_out,
  output logic irq_out
);

  typedef struct packed {
    logic [NUM_CH-1:0][7:0] ov_th;
    logic [NUM_CH-1:0][4:0] ov_hy;
    logic [NUM_CH-1:0][7:0] uv_th;
    logic [NUM_CH-1:0][4:0] uv_hy;
    logic [NUM_CH-1:0][7:0] sel;
    logic [NUM_CH-1:0][7:0] sync1;
    logic [NUM_CH-1:0][7:0] sync2;
    logic [NUM_CH-1:0] uv_f;
    logic [NUM_CH-1:0] ov_f;
    logic [NUM_CH-1:0] filt;
    logic [NUM_CH-1:0][sfm_pkg::CNT_W-1:0] cnt;
    logic [NUM_CH-1:0][2:0] rng;
    logic [NUM_CH-1:0] stat;
    logic [NUM_CH-1:0] mask;
    logic [7:0] rdata;
    logic irq;
  } sfm_state_t;

  sfm_state_t q;
  sfm_state_t d;
  logic [NUM_CH-1:0] raw_flt;
  logic [NUM_CH-1:0] rise;
  logic [NUM_CH-1:0] clr;
  logic [7:0] rel;
  logic in_ch;
  logic [2:0] ch_idx;
  logic [2:0] ch_off;

  // glitch timeout in clock cycles
  function automatic logic [sfm_pkg::CNT_W-1:0] gf_cycles(input logic [7:0] sel);
    gf_cycles = sfm_pkg::CNT_W'(sfm_pkg::gf_us(sel[sfm_pkg::SEL_GF_LSB +: 3]) * CYC_PER_US);
  endfunction

  // selected fault type applied to the two comparator states
  function automatic logic pick_fault(input logic [7:0] sel, input logic uv, input logic ov);
    case (sel[sfm_pkg::SEL_TYPE_LSB +: 2])
      sfm_pkg::FT_UV: pick_fault = uv;
      sfm_pkg::FT_OV: pick_fault = ov;
      default: pick_fault = uv | ov;
    endcase
  endfunction

  always_comb
  begin
    d = q;
    raw_flt = '0;
    rise = '0;
    clr = '0;
    rel = addr_in - sfm_pkg::CH_BASE;
    in_ch = (addr_in >= sfm_pkg::CH_BASE) && (addr_in <= sfm_pkg::CH_LAST);
    ch_idx = rel[5:3];
    ch_off = rel[2:0];
    // register writes
    if (wr_en_in && in_ch)
    begin
      case (ch_off)
        sfm_pkg::OFF_OV_TH: d.ov_th[ch_idx] = wr_data_in; // RULE_04 RULE_16
        sfm_pkg::OFF_OV_HY: d.ov_hy[ch_idx] = wr_data_in[sfm_pkg::HY_W-1:0]; // RULE_07
        sfm_pkg::OFF_UV_TH: d.uv_th[ch_idx] = wr_data_in; // RULE_04 RULE_16
        sfm_pkg::OFF_UV_HY: d.uv_hy[ch_idx] = wr_data_in[sfm_pkg::HY_W-1:0]; // RULE_07
        sfm_pkg::OFF_SEL: d.sel[ch_idx] = wr_data_in; // RULE_16
        default: ;
      endcase
    end
    if (wr_en_in && addr_in == sfm_pkg::ADDR_MASK)
      d.mask = wr_data_in[NUM_CH-1:0];
    if (wr_en_in && addr_in == sfm_pkg::ADDR_STATUS)
      clr = wr_data_in[NUM_CH-1:0];
    // per channel detection
    for (int i = 0; i < NUM_CH; i++) // RULE_01
    begin
      d.sync1[i] = sense_code_in[i*8 +: 8];
      d.sync2[i] = q.sync1[i];
      // codes are on the scale of the applied range: code 255 is the top
      if (!q.uv_f[i])
        d.uv_f[i] = q.sync2[i] < q.uv_th[i]; // RULE_03 RULE_05
      else
        d.uv_f[i] = !({1'b0, q.sync2[i]} > ({1'b0, q.uv_th[i]} + {4'h0, q.uv_hy[i]})); // RULE_08 RULE_09
      if (!q.ov_f[i])
        d.ov_f[i] = q.sync2[i] > q.ov_th[i]; // RULE_03 RULE_05
      else
        d.ov_f[i] = !(({1'b0, q.sync2[i]} + {4'h0, q.ov_hy[i]}) < {1'b0, q.ov_th[i]}); // RULE_08
      raw_flt[i] = pick_fault(q.sel[i], q.uv_f[i], q.ov_f[i]); // RULE_02 RULE_12
      // filter: output follows only after raw has differed for the full timeout
      if (raw_flt[i] == q.filt[i])
        d.cnt[i] = '0; // RULE_14
      else if (gf_cycles(q.sel[i]) == '0 || q.cnt[i] == gf_cycles(q.sel[i]) - 1'b1)
      begin
        d.filt[i] = raw_flt[i]; // RULE_13 RULE_14
        d.cnt[i] = '0;
      end
      else
        d.cnt[i] = q.cnt[i] + 1'b1;
      d.rng[i] = 3'(sfm_pkg::eff_range(i, q.sel[i])); // RULE_06 RULE_10 RULE_11 RULE_18
    end
    rise = d.filt & ~q.filt;
    d.stat = (q.stat & ~clr) | rise;
    d.irq = |(d.stat & d.mask);
    // read data stand for one cycle only
    d.rdata = 8'h00;
    if (rd_en_in)
    begin
      if (in_ch)
        case (ch_off)
          sfm_pkg::OFF_OV_TH: d.rdata = q.ov_th[ch_idx];
          sfm_pkg::OFF_OV_HY: d.rdata = {3'h0, q.ov_hy[ch_idx]};
          sfm_pkg::OFF_UV_TH: d.rdata = q.uv_th[ch_idx];
          sfm_pkg::OFF_UV_HY: d.rdata = {3'h0, q.uv_hy[ch_idx]};
          sfm_pkg::OFF_SEL: d.rdata = q.sel[ch_idx];
          default: d.rdata = 8'h00;
        endcase
      else if (addr_in == sfm_pkg::ADDR_STATUS)
        d.rdata = {1'b0, q.stat};
      else if (addr_in == sfm_pkg::ADDR_MASK)
        d.rdata = {1'b0, q.mask};
      else if (addr_in == sfm_pkg::ADDR_LIVE)
        d.rdata = {1'b0, q.filt};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      q <= '0;
      q.ov_th <= {NUM_CH{sfm_pkg::OV_TH_RST}}; // RULE_17
      q.uv_th <= {NUM_CH{sfm_pkg::UV_TH_RST}}; // RULE_17
      q.ov_hy <= {NUM_CH{sfm_pkg::HY_RST}};
      q.uv_hy <= {NUM_CH{sfm_pkg::HY_RST}};
      q.sel <= {NUM_CH{sfm_pkg::SEL_RST}};
      q.mask <= sfm_pkg::MASK_RST;
    end
    else
      q <= d;
  end

  assign rd_data_out = q.rdata;
  assign fault_out = q.filt;
  assign range_out = q.rng;
  assign irq_out = q.irq;

  a_ov_reset_ones: assert property (@(posedge clk_in) // RULE_17
    $rose(reset_n_in) |-> (q.ov_th == {NUM_CH{8'hFF}} && q.sel == '0 && q.uv_th == '0))
    else $error("high thresholds or selects wrong after reset");

  a_hyst_five_bits: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_07
    (wr_en_in && in_ch && ch_off == sfm_pkg::OFF_UV_HY)
    ##2 (rd_en_in && addr_in == $past(addr_in, 2) && !$past(wr_en_in))
    |=> rd_data_out == ($past(wr_data_in, 3) & 8'h1F))
    else $error("hysteresis readback not five bits");

  a_irq_level: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_16
    irq_out == |(q.stat & q.mask))
    else $error("interrupt level disagrees with status and mask");

  a_status_sticky: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_16
    (rise != '0) |=> ((q.stat & $past(rise)) == $past(rise)))
    else $error("status lost a fault rise");

  a_read_one_cycle: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_16
    !rd_en_in |=> rd_data_out == 8'h00)
    else $error("read data outside its cycle");

  a_reset_quiet: assert property (@(posedge clk_in) // RULE_17
    $rose(reset_n_in) |-> (fault_out == '0 && irq_out == 1'b0 && rd_data_out == 8'h00))
    else $error("outputs not quiet after reset");

  a_reset_hyst_zero: assert property (@(posedge clk_in) // RULE_17
    $rose(reset_n_in) |-> (q.ov_hy == '0 && q.uv_hy == '0 && q.mask == '0))
    else $error("hysteresis or mask not zero after reset");

  a_mask_write: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_16
    (wr_en_in && addr_in == sfm_pkg::ADDR_MASK)
    |=> q.mask == $past(wr_data_in[NUM_CH-1:0]))
    else $error("mask write not applied");

  a_status_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_16
    (wr_en_in && addr_in == sfm_pkg::ADDR_STATUS && rise == '0)
    |=> (q.stat & $past(wr_data_in[NUM_CH-1:0])) == '0)
    else $error("status bits not cleared by a one");

  a_live_read: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_13
    (rd_en_in && addr_in == sfm_pkg::ADDR_LIVE) |=> rd_data_out == {1'b0, $past(q.filt)})
    else $error("live fault readback wrong");

  a_status_read: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_16
    (rd_en_in && addr_in == sfm_pkg::ADDR_STATUS) |=> rd_data_out == {1'b0, $past(q.stat)})
    else $error("status readback wrong");

  a_gap_read_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_16
    (rd_en_in && in_ch && ch_off > sfm_pkg::OFF_SEL) |=> rd_data_out == 8'h00)
    else $error("unmapped channel slot did not read zero");

  a_ovth_write: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_04
    (wr_en_in && in_ch && ch_off == sfm_pkg::OFF_OV_TH)
    |=> q.ov_th[$past(ch_idx)] == $past(wr_data_in))
    else $error("high threshold write not applied");

  a_uvth_write: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_04
    (wr_en_in && in_ch && ch_off == sfm_pkg::OFF_UV_TH)
    |=> q.uv_th[$past(ch_idx)] == $past(wr_data_in))
    else $error("low threshold write not applied");

  a_sel_write: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_16
    (wr_en_in && in_ch && ch_off == sfm_pkg::OFF_SEL)
    |=> q.sel[$past(ch_idx)] == $past(wr_data_in))
    else $error("select write not applied");

  a_ovhy_write: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_07
    (wr_en_in && in_ch && ch_off == sfm_pkg::OFF_OV_HY)
    |=> q.ov_hy[$past(ch_idx)] == $past(wr_data_in[sfm_pkg::HY_W-1:0]))
    else $error("high hysteresis write not five bits");

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_chk
    a_uv_trip: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_03
      (!q.uv_f[g] && q.sync2[g] < q.uv_th[g]) |=> q.uv_f[g])
      else $error("undervoltage did not trip");

    a_uv_release: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_08
      (q.uv_f[g] && {1'b0, q.sync2[g]} <= {1'b0, q.uv_th[g]} + {4'h0, q.uv_hy[g]})
      |=> q.uv_f[g])
      else $error("undervoltage released inside hysteresis");

    a_ov_release: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_08
      (q.ov_f[g] && {1'b0, q.sync2[g]} + {4'h0, q.ov_hy[g]} >= {1'b0, q.ov_th[g]})
      |=> q.ov_f[g])
      else $error("overvoltage released inside hysteresis");

    a_window_or: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_12
      q.sel[g][1] |-> raw_flt[g] == (q.uv_f[g] | q.ov_f[g]))
      else $error("window fault is not the OR");

    a_glitch_delay: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_14
      ($changed(q.filt[g]) && $past(gf_cycles(q.sel[g])) != '0)
      |-> $past(q.cnt[g]) == $past(gf_cycles(q.sel[g])) - 1'b1)
      else $error("filter output moved before its timeout");

    a_ov_trip: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_03
      (!q.ov_f[g] && q.sync2[g] > q.ov_th[g]) |=> q.ov_f[g])
      else $error("overvoltage did not trip");

    a_uv_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_08
      (q.uv_f[g] && {1'b0, q.sync2[g]} > {1'b0, q.uv_th[g]} + {4'h0, q.uv_hy[g]})
      |=> !q.uv_f[g])
      else $error("undervoltage held past hysteresis");

    a_ov_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_08
      (q.ov_f[g] && {1'b0, q.sync2[g]} + {4'h0, q.ov_hy[g]} < {1'b0, q.ov_th[g]})
      |=> !q.ov_f[g])
      else $error("overvoltage held past hysteresis");

    a_type_uv: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_02
      q.sel[g][1:0] == 2'h0 |-> raw_flt[g] == q.uv_f[g])
      else $error("undervoltage type not applied");

    a_type_ov: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_02
      q.sel[g][1:0] == 2'h1 |-> raw_flt[g] == q.ov_f[g])
      else $error("overvoltage type not applied");

    a_filter_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_14
      (gf_cycles(q.sel[g]) == '0 && raw_flt[g]) |=> q.filt[g])
      else $error("zero timeout filter did not pass fault");

    a_filter_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_14
      (raw_flt[g] == q.filt[g]) |=> q.filt[g] == $past(q.filt[g]))
      else $error("filter output moved without cause");

    a_rise_status: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_13
      $rose(q.filt[g]) |-> q.stat[g])
      else $error("fault rise not recorded in status");

    if (g >= sfm_pkg::CH_POS_FIRST)
    begin : g_pos
      a_pos_range: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_06
        q.rng[g] != 3'(sfm_pkg::RG_HIGH) && q.rng[g] != 3'(sfm_pkg::RG_NEG))
        else $error("positive-only channel in foreign range");
    end

    if (g == sfm_pkg::CH_HV)
    begin : g_hv
      a_hv_range: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_06
        q.rng[g] == 3'(sfm_pkg::RG_MID) || q.rng[g] == 3'(sfm_pkg::RG_HIGH))
        else $error("high-voltage channel in foreign range");
    end

    if (g <= sfm_pkg::CH_BIP1)
    begin : g_bip
      a_neg_range: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_11
        q.sel[g][7] |=> q.rng[g] == 3'(sfm_pkg::RG_NEG))
        else $error("negative polarity did not force negative range");

      a_pos_bip_range: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RULE_10
        !q.sel[g][7] |=> (q.rng[g] == 3'(sfm_pkg::RG_MID) || q.rng[g] == 3'(sfm_pkg::RG_LOW)))
        else $error("positive bipolar channel in foreign range");
    end
  end

endmodule // sfm_fault_detector

// ---- tb/sfm_rail_model.sv ----
// model of the monitored rails, driving one measured level code per channel
`timescale 1ns/10ps
module sfm_rail_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic set_in,
  input wire logic [2:0] ch_in,
  input wire logic [7:0] level_in,
  output logic [55:0] sense_code_out
);
  // one rail per input; a rail watched two ways is wired to two inputs
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      sense_code_out <= {7{8'h90}};
    else if (set_in)
      sense_code_out[ch_in*8 +: 8] <= level_in;
  end
endmodule // sfm_rail_model

// ---- tb/test_supply_fault_detector.sv ----
// self-checking bench for the supply fault monitor
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module test_supply_fault_detector;
  logic clk_in = 0, reset_n_in = 0, wr_en = 0, rd_en = 0, set = 0, rd_v = 0, irq;
  logic [7:0] addr = 0, wdat = 0, lvl = 0, rdata;
  logic [2:0] ch = 0;
  logic [55:0] sense;
  logic [6:0] fault;
  logic [20:0] rng;
  logic [7:0] exp_q[$];
  logic [7:0] mem[35];
  int err_count = 0, samples_checked = 0, seed = 92363;
  initial forever #2 clk_in = ~clk_in;
  sfm_fault_detector #(.CYC_PER_US(2)) i_sfm_fault_detector (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .addr_in(addr), .wr_data_in(wdat), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .rd_data_out(rdata), .sense_code_in(sense), .fault_out(fault),
    .range_out(rng), .irq_out(irq));
  sfm_rail_model i_sfm_rail_model (.clk_in(clk_in), .reset_n_in(reset_n_in), .set_in(set),
    .ch_in(ch), .level_in(lvl), .sense_code_out(sense));
  always @(posedge clk_in)
  begin : mon
    logic [7:0] e;
    rd_v <= rd_en;
    if (rd_v)
    begin
      e = exp_q.pop_front();
      `CHK(rdata, e)
    end
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_en <= 1;
    addr <= a;
    wdat <= d;
    @(posedge clk_in);
    wr_en <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd_en <= 1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk_in);
    rd_en <= 0;
  endtask
  task lv(input logic [2:0] c, input logic [7:0] v, input int w);
    @(posedge clk_in);
    set <= 1;
    ch <= c;
    lvl <= v;
    @(posedge clk_in);
    set <= 0;
    repeat (w) @(posedge clk_in);
  endtask
  task step(input logic [2:0] c, input logic [7:0] v, input logic [7:0] e);
    lv(c, v, 8);
    `CHK(fault, e[6:0])
    rd(sfm_pkg::ADDR_LIVE, e);
  endtask
  task rst;
    @(posedge clk_in);
    reset_n_in <= 0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1;
  endtask
  task settle;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  function automatic logic [7:0] ra(input int c, input int o);
    return sfm_pkg::CH_BASE + 8'(8 * c + o);
  endfunction
  task report_and_stop;
    $display("checked %0d, failed %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    report_and_stop;
  end
  initial
  begin
    rst;
    for (int i = 0; i < 35; i++)
      rd(ra(i / 5, i % 5), (i % 5 == 0) ? sfm_pkg::OV_TH_RST : 8'h00);
    rd(8'hA5, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 35; i++)
    begin
      mem[i] = 8'($random(seed));
      wr(ra(i / 5, i % 5), mem[i]);
      if (i % 5 == 1 || i % 5 == 3)
        mem[i] = mem[i] & 8'h1F;
    end
    for (int i = 0; i < 35; i++)
      rd(ra(i / 5, i % 5), mem[i]);
    wr(ra(2, 3), 8'hFF);
    rd(ra(2, 3), 8'h1F);
    $display("test register access done");
    rst;
    wr(ra(0, 4), 8'h80);
    wr(ra(2, 4), 8'h0C);
    wr(ra(3, 4), 8'h08);
    wr(ra(1, 4), 8'h04);
    settle;
    `CHK(rng[5:3], 3'(sfm_pkg::RG_LOW))
    `CHK(rng[2:0], 3'(sfm_pkg::RG_NEG))
    `CHK(rng[8:6], 3'(sfm_pkg::RG_HIGH))
    `CHK(rng[11:9], 3'(sfm_pkg::RG_ULOW))
    wr(ra(3, 2), 8'h80);
    wr(ra(3, 3), 8'hE4);
    step(3, 8'h10, 8'h08);
    step(3, 8'h84, 8'h08);
    step(3, 8'h85, 8'h00);
    wr(ra(4, 4), 8'h01);
    wr(ra(4, 0), 8'hC0);
    wr(ra(4, 1), 8'h03);
    step(4, 8'hC1, 8'h10);
    step(4, 8'hBD, 8'h10);
    step(4, 8'hBC, 8'h00);
    wr(ra(5, 4), 8'h02);
    wr(ra(5, 2), 8'h40);
    wr(ra(5, 0), 8'hC0);
    step(5, 8'h30, 8'h20);
    step(5, 8'h90, 8'h00);
    step(5, 8'hD0, 8'h20);
    step(5, 8'h90, 8'h00);
    $display("test fault types done");
    rd(sfm_pkg::ADDR_STATUS, 8'h38);
    settle;
    `CHK(irq, 1'b0)
    wr(sfm_pkg::ADDR_MASK, 8'h08);
    settle;
    `CHK(irq, 1'b1)
    wr(sfm_pkg::ADDR_STATUS, 8'h7F);
    settle;
    `CHK(irq, 1'b0)
    rd(sfm_pkg::ADDR_STATUS, 8'h00);
    wr(ra(6, 4), 8'h30);
    wr(ra(6, 2), 8'h80);
    lv(6, 8'h10, 3);
    lv(6, 8'h90, 20);
    rd(sfm_pkg::ADDR_STATUS, 8'h00);
    lv(6, 8'h10, 30);
    rd(sfm_pkg::ADDR_STATUS, 8'h40);
    lv(6, 8'h90, 4);
    $display("test glitch filter done");
    report_and_stop;
  end
endmodule // test_supply_fault_detector
